// ---- hw/dtms_sequencer.sv ----
/*
 * Channel sequencer of a four channel DMA controller, with a transfer
 * log FIFO. Assumes synchronous inputs, an external bus hold handshake
 * and a consumer that drains the log FIFO.
 */
// Notes on behaviour
// - Each channel runs single, block, demand or cascade mode.
// - Single mode does one transfer, drops hold, waits grant removal.
// - Each transfer decrements count and steps address up or down; ch0 address stays fixed in a copy with ch0_addr_hold.
// - Count wrapping past zero sets status bit and pulses terminal count.
// - Without auto-init, terminal count sets the mask bit and stops.
// - Block mode starts on request or software, runs to terminal count.
// - Demand mode runs while request stays, stops on withdrawal or count.
// - Cascade channel drives no address or command, forwards hold grant.
// - During cascade grant only hold grant and its request are watched.
// - Word-wide controller has channel 0 permanently in cascade.
// - Acknowledges reset active-low and inactive; polarity is fixed.
// - Read type drives address, memory read and I/O write together.
// - Write type drives address, memory write and I/O read together.
// - Verify runs the full sequence with no commands, ignores ready.
// - Memory copy uses channels 0 and 1, enabled, started by channel 0.
// - Copy holds read byte in temp, drives it on write; ends at ch1 count.
// - Auto-init reloads current from base copies; base only CPU written.
// - Fixed priority ranks channel 0 first; service runs uninterrupted.
// - Rotating priority puts last serviced channel lowest.
// - Hold raised at once; priority frozen at grant until grant drops.
// - After grant, resolve and acknowledge, address, command, ready, end.

// ==============================================================
// Log FIFO
// ==============================================================
module dtms_fifo #(
	parameter int WIDTH = 19,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             resetn,
	input  wire logic             ce,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0]   cnt;
	} dtms_fifo_state_type;

	dtms_fifo_state_type q;
	dtms_fifo_state_type d;
	logic [WIDTH-1:0]    mem [DEPTH];
	logic                do_wr;
	logic                do_rd;

	assign in_ready  = (q.cnt != FULL);
	assign out_valid = (q.cnt != '0);
	assign out_data  = mem[q.rd];
	assign do_wr     = in_valid && in_ready;
	assign do_rd     = out_valid && out_ready;

	always_comb begin
		d = q;
		if (do_wr) begin
			d.wr = q.wr + 1'b1;
		end
		if (do_rd) begin
			d.rd = q.rd + 1'b1;
		end
		d.cnt = q.cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	always_ff @(posedge mclk) begin
		if (ce && do_wr) begin
			mem[q.wr] <= in_data;
		end
	end
endmodule // dtms_fifo

// ==============================================================
// Sequencer
// ==============================================================
module dtms_sequencer #(
	parameter bit WORD_WIDE = 1'b0
) (
	// Clock and reset
	input  wire logic                     mclk,
	input  wire logic                     resetn,
	input  wire logic                     ce,
	// Peripheral requests and acknowledges
	input  wire logic [3:0]               dreq,
	output logic [3:0]                    dack_n,
	// Bus hold handshake
	output logic                          system_hold_request,
	input  wire logic                     hlda,
	// Bus commands and address
	output logic                          memr_n,
	output logic                          memw_n,
	output logic                          ior_n,
	output logic                          iow_n,
	output logic [15:0]                   addr,
	output logic                          addr_oe,
	input  wire logic                     iochrdy,
	// Data bus for memory copies
	input  wire logic [7:0]               sd_in,
	output logic [7:0]                    sd_out,
	output logic                          sd_oe,
	// Channel programming
	input  wire logic                     cfg_wr,
	input  wire logic [1:0]               cfg_sel,
	input  wire dtms_pkg::dtms_cfg_type   cfg_in,
	input  wire logic                     addr_wr,
	input  wire logic                     cnt_wr,
	input  wire logic [1:0]               wr_sel,
	input  wire logic [15:0]              wr_data,
	// Global control
	input  wire logic                     m2m_enable,
	input  wire logic                     ch0_addr_hold,
	input  wire logic                     rotate_priority,
	input  wire logic [3:0]               sw_request,
	input  wire logic [3:0]               mask_set,
	input  wire logic [3:0]               mask_clr,
	input  wire logic [3:0]               tc_clear,
	// Status
	output logic                          terminal_count_pulse,
	output logic [3:0]                    tc_status,
	output logic [3:0]                    mask,
	// Transfer log
	output logic                          log_valid,
	input  wire logic                     log_ready,
	output dtms_pkg::dtms_log_type        log_data
);
	import dtms_pkg::*;

	dtms_regs_type q;
	dtms_regs_type d;
	dtms_log_type  log_rec;
	logic [3:0]    req_c;
	logic [3:0]    step;
	logic [3:0]    tc_hit;
	logic [3:0]    ai_vec;
	logic [3:0]    tc_noai;
	logic [1:0]    pk;
	logic          push;
	logic          push_ready;
	logic          stop;
	logic          verify;
	logic          single_end;
	dtms_mode_type mode_v;

	// ==========================================================
	// Helpers
	// ==========================================================
	function automatic logic [1:0] pick(logic [3:0] r, logic [1:0] last,
			logic rot);
		logic [1:0] base;
		logic [1:0] idx;
		pick = 2'h0;
		base = rot ? last + 2'h1 : 2'h0;
		for (int k = 3; k >= 0; k--) begin
			idx = base + k[1:0];
			if (r[idx]) begin
				pick = idx;
			end
		end
	endfunction

	function automatic dtms_mode_type mode_of(logic [1:0] c);
		mode_of = (WORD_WIDE && c == 2'h0) ? MODE_CASCADE
		                                   : q.cfg[c].mode;
	endfunction

	function automatic dtms_chan_type advance(dtms_chan_type c,
			logic dec, logic fix, logic ai);
		advance = c;
		if (!fix) begin
			advance.cur_addr = dec ? c.cur_addr - ADDR_STEP
			                       : c.cur_addr + ADDR_STEP;
		end
		if (c.cur_cnt == CNT_LAST && ai) begin
			advance.cur_addr = c.base_addr;
			advance.cur_cnt  = c.base_cnt;
		end else begin
			advance.cur_cnt = c.cur_cnt - ADDR_STEP;
		end
	endfunction

	// ==========================================================
	// Next state
	// ==========================================================
	always_comb begin
		d          = q;
		d.tc_pulse = 1'b0;
		step       = '0;
		tc_hit     = '0;
		push       = 1'b0;
		stop       = 1'b0;
		single_end = 1'b0;
		req_c      = (dreq & ~q.mask) | sw_request;
		pk         = pick(req_c, q.last, rotate_priority);
		mode_v     = mode_of(q.ch);
		verify     = !q.m2m && q.cfg[q.ch].xtype == TYPE_VERIFY;
		for (int i = 0; i < CH_COUNT; i++) begin
			ai_vec[i] = q.cfg[i].autoinit;
		end
		if (cfg_wr) begin
			d.cfg[cfg_sel] = cfg_in;
		end
		if (addr_wr) begin
			d.chan[wr_sel].base_addr = wr_data;
			d.chan[wr_sel].cur_addr  = wr_data;
		end
		if (cnt_wr) begin
			d.chan[wr_sel].base_cnt = wr_data;
			d.chan[wr_sel].cur_cnt  = wr_data;
		end
		d.mask      = (q.mask | mask_set) & ~mask_clr;
		d.tc_status = q.tc_status & ~tc_clear;
		case (q.st)
			ST_IDLE: begin
				if (|req_c) begin
					d.hold = 1'b1;
					d.st   = ST_HOLD;
				end
			end
			ST_HOLD: begin
				if (!(|req_c)) begin
					d.hold = 1'b0;
					d.st   = ST_REL;
				end else if (hlda) begin
					d.st = ST_S0;
				end
			end
			ST_S0: begin
				d.phase = 1'b0;
				if (!(|req_c)) begin
					d.hold = 1'b0;
					d.st   = ST_REL;
				end else begin
					d.ch   = pk;
					d.last = pk;
					d.m2m  = m2m_enable && pk == 2'h0 &&
					         mode_of(pk) != MODE_CASCADE;
					if (mode_of(pk) == MODE_CASCADE) begin
						d.dack_n[pk] = 1'b0;
						d.st         = ST_CASC;
					end else begin
						d.dack_n[pk] = d.m2m;
						d.st         = ST_S1;
					end
				end
			end
			ST_CASC: begin
				if (!hlda || !dreq[q.ch]) begin
					d.hold   = 1'b0;
					d.dack_n = DACK_IDLE;
					d.st     = ST_REL;
				end
			end
			ST_S1: begin
				d.addr    = (q.m2m && q.phase) ? q.chan[1].cur_addr
				                               : q.chan[q.ch].cur_addr;
				d.addr_oe = 1'b1;
				d.st      = ST_S2;
			end
			ST_S2: begin
				if (q.m2m) begin
					d.memr_n = q.phase;
					d.memw_n = !q.phase;
					d.sd_oe  = q.phase;
				end else if (q.cfg[q.ch].xtype == TYPE_READ) begin
					d.memr_n = 1'b0;
					d.iow_n  = 1'b0;
				end else if (q.cfg[q.ch].xtype == TYPE_WRITE) begin
					d.memw_n = 1'b0;
					d.ior_n  = 1'b0;
				end
				d.wait_cnt = WAIT_STATES;
				d.st       = ST_S3;
			end
			ST_S3: begin
				if (q.wait_cnt != 2'h0) begin
					d.wait_cnt = q.wait_cnt - 2'h1;
				end else if (verify || iochrdy) begin
					d.memr_n = 1'b1;
					d.memw_n = 1'b1;
					d.ior_n  = 1'b1;
					d.iow_n  = 1'b1;
					d.sd_oe  = 1'b0;
					if (q.m2m && !q.phase) begin
						d.temp = sd_in;
					end
					d.st = ST_S4;
				end
			end
			ST_S4: begin
				if (q.m2m && !q.phase) begin
					d.phase = 1'b1;
					d.st    = ST_S1;
				end else if (push_ready) begin
					push  = 1'b1;
					step  = q.m2m ? 4'h3 : 4'h1 << q.ch;
					for (int i = 0; i < CH_COUNT; i++) begin
						if (step[i]) begin
							tc_hit[i] = q.chan[i].cur_cnt == CNT_LAST;
							d.chan[i] = advance(q.chan[i],
								q.cfg[i].address_decrement_select,
								i == 0 && q.m2m && ch0_addr_hold,
								q.cfg[i].autoinit);
							if (tc_hit[i]) begin
								d.tc_status[i] = 1'b1;
								d.tc_pulse     = 1'b1;
								if (!q.cfg[i].autoinit) begin
									d.mask[i] = 1'b1;
								end
							end
						end
					end
					d.phase = 1'b0;
					if (q.m2m) begin
						stop = tc_hit[1];
					end else begin
						case (mode_v)
							MODE_SINGLE: begin
								stop       = 1'b1;
								single_end = 1'b1;
							end
							MODE_BLOCK: begin
								stop = tc_hit[q.ch];
							end
							MODE_DEMAND: begin
								stop = tc_hit[q.ch] || !req_c[q.ch];
							end
							default: begin
								stop = 1'b1;
							end
						endcase
					end
					if (stop) begin
						d.hold    = 1'b0;
						d.dack_n  = DACK_IDLE;
						d.addr_oe = 1'b0;
						d.st      = ST_REL;
					end else begin
						d.st = ST_S1;
					end
				end
			end
			ST_REL: begin
				if (!hlda) begin
					d.st = ST_IDLE;
				end
			end
			default: begin
				d = REGS_RESET;
			end
		endcase
		tc_noai = tc_hit & ~ai_vec;
	end

	assign log_rec.ch   = q.m2m ? 2'h1 : q.ch;
	assign log_rec.tc   = |tc_hit;
	assign log_rec.addr = q.addr;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			q <= REGS_RESET;
		end else if (ce) begin
			q <= d;
		end
	end

	// ==========================================================
	// Log FIFO and outputs
	// ==========================================================
	dtms_fifo #(
		.WIDTH ($bits(dtms_log_type)),
		.DEPTH (LOG_DEPTH)
	) u_log (
		.mclk      (mclk),
		.resetn    (resetn),
		.ce        (ce),
		.in_valid  (push && ce),
		.in_ready  (push_ready),
		.in_data   (log_rec),
		.out_valid (log_valid),
		.out_ready (log_ready),
		.out_data  (log_data)
	);

	assign dack_n               = q.dack_n;
	assign system_hold_request  = q.hold;
	assign memr_n               = q.memr_n;
	assign memw_n               = q.memw_n;
	assign ior_n                = q.ior_n;
	assign iow_n                = q.iow_n;
	assign addr                 = q.addr;
	assign addr_oe              = q.addr_oe;
	assign sd_out               = q.temp;
	assign sd_oe                = q.sd_oe;
	assign terminal_count_pulse = q.tc_pulse;
	assign tc_status            = q.tc_status;
	assign mask                 = q.mask;

	// ==========================================================
	// Assertions
	// ==========================================================
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);

	a_ack_onehot:
	assert property ($onehot0(~dack_n))
		else $error("More than one acknowledge active.");
	a_ack_hold:
	assert property (!(&dack_n) |-> system_hold_request)
		else $error("Acknowledge without hold request.");
	a_read_pair:
	assert property ((!memr_n && !q.m2m) |-> !iow_n && memw_n && ior_n)
		else $error("Read transfer command pair broken.");
	a_write_pair:
	assert property ((!memw_n && !q.m2m) |-> !ior_n && memr_n && iow_n)
		else $error("Write transfer command pair broken.");
	a_verify_quiet:
	assert property ((verify && q.st inside {ST_S2, ST_S3, ST_S4}) |->
		memr_n && memw_n && ior_n && iow_n)
		else $error("Command issued during verify.");
	a_cascade_quiet:
	assert property (q.st == ST_CASC |->
		memr_n && memw_n && ior_n && iow_n && !addr_oe)
		else $error("Cascade channel drove the bus.");
	a_tc_status:
	assert property ((|tc_hit) && ce |=>
		terminal_count_pulse && ((tc_status & $past(tc_hit)) != 4'h0))
		else $error("Terminal count not reported.");
	a_tc_mask:
	assert property ((|tc_noai) && ce |=>
		(mask & $past(tc_noai)) == $past(tc_noai))
		else $error("Mask not set at terminal count.");
	a_single_drop:
	assert property (single_end && ce |=> !system_hold_request ##1
		(!system_hold_request || !hlda))
		else $error("Hold not released after single transfer.");
	a_s3_wait:
	assert property ((q.st == ST_S2 && ce) |=> q.st == ST_S3 [*2])
		else $error("Wait state missing.");

	c_single: cover property (single_end && ce);
	c_block_tc: cover property (push && mode_v == MODE_BLOCK && stop);
	c_cascade: cover property (q.st == ST_CASC);
	c_copy: cover property (q.m2m && !memw_n && sd_oe);
endmodule // dtms_sequencer

// ---- hw/dtms_pkg.sv ----
/*
 * Shared types and constants of the DMA transfer mode sequencer.
 * Assumes a single clock domain and synchronous inputs.
 */
package dtms_pkg;

	// ==========================================================
	// Sizes, reset values and counts
	// ==========================================================
	localparam int          CH_COUNT    = 4;
	localparam int          LOG_DEPTH   = 16;
	localparam logic [15:0] CNT_LAST    = 16'h0000;
	localparam logic [15:0] ADDR_STEP   = 16'h0001;
	localparam logic [3:0]  MASK_RESET  = 4'hF;
	localparam logic [3:0]  DACK_IDLE   = 4'hF;
	localparam logic [1:0]  WAIT_STATES = 2'h1;

	// ==========================================================
	// Enumerations
	// ==========================================================
	typedef enum logic [1:0] {
		MODE_DEMAND, MODE_SINGLE, MODE_BLOCK, MODE_CASCADE
	} dtms_mode_type;

	typedef enum logic [1:0] {
		TYPE_VERIFY, TYPE_WRITE, TYPE_READ, TYPE_SPARE
	} dtms_xfer_type;

	typedef enum logic [3:0] {
		ST_IDLE, ST_HOLD, ST_S0, ST_S1, ST_S2, ST_S3, ST_S4,
		ST_CASC, ST_REL
	} dtms_state_type;

	// ==========================================================
	// Structures
	// ==========================================================
	typedef struct packed {
		dtms_mode_type mode;
		dtms_xfer_type xtype;
		logic          address_decrement_select;
		logic          autoinit;
	} dtms_cfg_type;

	typedef struct packed {
		logic [15:0] base_addr;
		logic [15:0] base_cnt;
		logic [15:0] cur_addr;
		logic [15:0] cur_cnt;
	} dtms_chan_type;

	typedef struct packed {
		logic [1:0]  ch;
		logic        tc;
		logic [15:0] addr;
	} dtms_log_type;

	typedef struct packed {
		dtms_state_type      st;
		logic [1:0]          ch;
		logic [1:0]          last;
		logic                m2m;
		logic                phase;
		logic [1:0]          wait_cnt;
		logic [7:0]          temp;
		logic [3:0]          mask;
		logic [3:0]          tc_status;
		dtms_cfg_type [3:0]  cfg;
		dtms_chan_type [3:0] chan;
		logic                hold;
		logic [3:0]          dack_n;
		logic                memr_n;
		logic                memw_n;
		logic                ior_n;
		logic                iow_n;
		logic [15:0]         addr;
		logic                addr_oe;
		logic                sd_oe;
		logic                tc_pulse;
	} dtms_regs_type;

	localparam dtms_regs_type REGS_RESET = '{
		st: ST_IDLE, mask: MASK_RESET, dack_n: DACK_IDLE,
		memr_n: 1'b1, memw_n: 1'b1, ior_n: 1'b1, iow_n: 1'b1,
		default: '0};

endpackage

// ---- verif/dtms_cpu_model.sv ----
/*
 * Bus hold model of the CPU side of the DMA channel sequencer.
 * Assumes one clock and an active low asynchronous reset.
 */
module dtms_cpu_model (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       resetn,
	// Hold handshake
	input  wire logic       system_hold_request,
	input  wire logic [2:0] grant_delay,
	output logic            hlda
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [2:0] wait_q;

	// ==========================================================
	// Grant after a delay, release when hold drops.
	// ==========================================================
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			hlda <= 1'b0;
			wait_q <= 3'h0;
		end else if (!system_hold_request) begin
			hlda <= 1'b0;
			wait_q <= 3'h0;
		end else if (wait_q >= grant_delay) begin
			hlda <= 1'b1;
		end else begin
			wait_q <= wait_q + 3'h1;
		end
	end
endmodule // dtms_cpu_model

// ---- verif/dma_transfer_mode_sequencer_tb.sv ----
/*
 * Self-checking bench of the DMA channel sequencer with its log FIFO.
 * Assumes the hold handshake model dtms_cpu_model on the CPU side.
 */
module dma_transfer_mode_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import dtms_pkg::*;

	// ==========================================================
	// Signals.
	// ==========================================================
	logic         mclk;
	logic         resetn = 1'b0;
	logic         ce = 1'b1;
	logic         ch0_addr_hold = 1'b0;
	logic         iochrdy = 1'b1;
	logic         cfg_wr = 1'b0;
	logic         addr_wr = 1'b0;
	logic         cnt_wr = 1'b0;
	logic         m2m_enable = 1'b0;
	logic         rotate_priority = 1'b0;
	logic         log_ready = 1'b1;
	logic [3:0]   dreq = 4'h0;
	logic [3:0]   sw_request = 4'h0;
	logic [3:0]   mask_set = 4'h0;
	logic [3:0]   mask_clr = 4'h0;
	logic [3:0]   tc_clear = 4'h0;
	logic [1:0]   cfg_sel = 2'h0;
	logic [1:0]   wr_sel = 2'h0;
	logic [15:0]  wr_data = 16'h0000;
	logic [7:0]   sd_in = 8'h00;
	logic [2:0]   grant_delay = 3'h0;
	dtms_cfg_type cfg_in = '0;
	logic         hlda, system_hold_request, memr_n, memw_n, ior_n;
	logic         iow_n, addr_oe, sd_oe, terminal_count_pulse, log_valid;
	logic [3:0]   dack_n, tc_status, mask;
	logic [15:0]  addr;
	logic [7:0]   sd_out;
	dtms_log_type log_data;
	dtms_log_type q[$];
	logic [4:0]   seen = 5'h00;
	logic         hold_p = 1'b0;
	logic [1:0]   lr_mode = 2'h0;
	logic [15:0]  a;
	logic [20:0]  snap;
	int           holds = 0;
	int           tcs = 0;
	int           mismatches = 0;
	int           total_checks = 0;
	int           seed = 63;
	int           k;

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	dtms_sequencer u_dut (
		.mclk(mclk), .resetn(resetn), .ce(ce),
		.dreq(dreq), .dack_n(dack_n),
		.system_hold_request(system_hold_request), .hlda(hlda),
		.memr_n(memr_n), .memw_n(memw_n), .ior_n(ior_n), .iow_n(iow_n),
		.addr(addr), .addr_oe(addr_oe), .iochrdy(iochrdy),
		.sd_in(sd_in), .sd_out(sd_out), .sd_oe(sd_oe),
		.cfg_wr(cfg_wr), .cfg_sel(cfg_sel), .cfg_in(cfg_in),
		.addr_wr(addr_wr), .cnt_wr(cnt_wr), .wr_sel(wr_sel),
		.wr_data(wr_data), .m2m_enable(m2m_enable),
		.ch0_addr_hold(ch0_addr_hold), .rotate_priority(rotate_priority),
		.sw_request(sw_request), .mask_set(mask_set),
		.mask_clr(mask_clr), .tc_clear(tc_clear),
		.terminal_count_pulse(terminal_count_pulse),
		.tc_status(tc_status), .mask(mask), .log_valid(log_valid),
		.log_ready(log_ready), .log_data(log_data)
	);

	dtms_cpu_model u_cpu (
		.mclk(mclk), .resetn(resetn),
		.system_hold_request(system_hold_request),
		.grant_delay(grant_delay), .hlda(hlda)
	);

	// ==========================================================
	// Monitor of the log, the commands and the hold line.
	// ==========================================================
	always @(posedge mclk) begin
		if (log_valid && log_ready) q.push_back(log_data);
		seen = seen | {addr_oe, ~memr_n, ~memw_n, ~ior_n, ~iow_n};
		holds = holds + int'(system_hold_request && !hold_p);
		tcs = tcs + int'(terminal_count_pulse);
		hold_p = system_hold_request;
		log_ready <= (lr_mode == 2'h2) ? 1'($random(seed) & 1)
			: (lr_mode == 2'h0);
		if (sd_oe === 1'b1) chk_bits(16'(sd_out), 16'(sd_in));
		if (!memr_n && ch0_addr_hold) chk_bits(addr, a);
	end

	// ==========================================================
	// Helpers.
	// ==========================================================
	task automatic bad(input string m);
		mismatches++;
		$display("BAD %0t %s", $time, m);
	endtask

	task automatic chk_bits(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e) bad($sformatf("value %h, expected %h", g, e));
	endtask

	task automatic chk_log(input dtms_log_type g, input dtms_log_type e);
		total_checks++;
		if (g !== e) bad($sformatf("log %h, expected %h", g, e));
	endtask

	function automatic logic [15:0] step(input logic [15:0] b,
		input logic d, input int i);
		return d ? b - 16'(i) : b + 16'(i);
	endfunction

	task automatic done(input string n);
		$display("test %s finished", n);
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic prog(input logic [1:0] c, input dtms_mode_type m,
		input dtms_xfer_type t, input logic d, input logic ai,
		input logic [15:0] b, input logic [15:0] n);
		@(posedge mclk);
		cfg_wr <= 1'b1;
		cfg_sel <= c;
		cfg_in <= '{m, t, d, ai};
		addr_wr <= 1'b1;
		wr_sel <= c;
		wr_data <= b;
		@(posedge mclk);
		cfg_wr <= 1'b0;
		addr_wr <= 1'b0;
		cnt_wr <= 1'b1;
		wr_data <= n;
		mask_clr <= 4'h1 << c;
		tc_clear <= 4'h1 << c;
		@(posedge mclk);
		cnt_wr <= 1'b0;
		mask_clr <= 4'h0;
		tc_clear <= 4'h0;
	endtask

	task automatic begin_test;
		@(posedge mclk);
		seen = 5'h00;
		holds = 0;
		tcs = 0;
		q.delete();
	endtask

	task automatic wait_q(input int n);
		for (k = 0; k < 3000 && q.size() < n; k++) @(posedge mclk);
		if (q.size() < n) bad("log entries missing");
	endtask

	task automatic idle;
		repeat (3) @(posedge mclk);
		for (k = 0; k < 500 && (system_hold_request || hlda); k++)
			@(posedge mclk);
		if (system_hold_request || hlda) bad("bus not released");
		repeat (3) @(posedge mclk);
	endtask

	task automatic expect_run(input logic [1:0] c, input logic d,
		input logic [15:0] b, input logic [15:0] n);
		for (int i = 0; i <= int'(n); i++)
			chk_log(q.pop_front(), '{c, i == int'(n), step(b, d, i)});
	endtask

	// ==========================================================
	// Stimulus and checks.
	// ==========================================================
	initial begin
		repeat (10) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		chk_bits(16'(dack_n), 16'h000F);
		chk_bits(16'({mask, tc_status}), 16'h00F0);
		chk_bits(16'({system_hold_request, memr_n, memw_n, ior_n,
			iow_n, addr_oe}), 16'h001E);
		done("reset");

		a = 16'($random(seed));
		prog(2'h2, MODE_BLOCK, TYPE_READ, 1'b0, 1'b0, a, 16'h0010);
		begin_test;
		lr_mode = 2'h1;
		dreq <= 4'h4;
		repeat (300) @(posedge mclk);
		chk_bits(16'({system_hold_request, tc_status}), 16'h0010);
		lr_mode = 2'h2;
		wait_q(17);
		dreq <= 4'h0;
		lr_mode = 2'h0;
		idle;
		expect_run(2'h2, 1'b0, a, 16'h0010);
		chk_bits(16'({tc_status, mask, dack_n}), 16'h04FF);
		chk_bits(16'(seen), 16'h0019);
		chk_bits(16'(tcs), 16'h0001);
		done("block read");

		a = 16'($random(seed));
		grant_delay <= 3'h3;
		prog(2'h1, MODE_SINGLE, TYPE_WRITE, 1'b1, 1'b0, a, 16'h0002);
		begin_test;
		dreq <= 4'h2;
		repeat (7) @(posedge mclk);
		ce <= 1'b0;
		@(posedge mclk);
		snap = {addr, dack_n, memw_n};
		repeat (10) @(posedge mclk);
		chk_bits(addr, snap[20:5]);
		chk_bits(16'({dack_n, memw_n}), 16'(snap[4:0]));
		ce <= 1'b1;
		wait_q(3);
		dreq <= 4'h0;
		idle;
		expect_run(2'h1, 1'b1, a, 16'h0002);
		chk_bits(16'(holds), 16'h0003);
		chk_bits(16'(seen), 16'h0016);
		done("single write");

		a = 16'($random(seed));
		grant_delay <= 3'($random(seed));
		iochrdy <= 1'b0;
		prog(2'h3, MODE_DEMAND, TYPE_VERIFY, 1'b0, 1'b0, a, 16'h0003);
		begin_test;
		dreq <= 4'h8;
		wait_q(4);
		dreq <= 4'h0;
		iochrdy <= 1'b1;
		idle;
		expect_run(2'h3, 1'b0, a, 16'h0003);
		chk_bits(16'(holds), 16'h0001);
		chk_bits(16'({seen, mask[3]}), 16'h0021);
		done("demand verify");

		grant_delay <= 3'h0;
		prog(2'h0, MODE_BLOCK, TYPE_READ, 1'b0, 1'b1, a, 16'h0001);
		begin_test;
		sw_request <= 4'h1;
		wait_q(4);
		chk_bits(16'({tc_status[0], mask[0]}), 16'h0002);
		sw_request <= 4'h0;
		idle;
		expect_run(2'h0, 1'b0, a, 16'h0001);
		expect_run(2'h0, 1'b0, a, 16'h0001);
		done("auto init");

		grant_delay <= 3'h5;
		prog(2'h1, MODE_SINGLE, TYPE_READ, 1'b0, 1'b0, a, 16'h0000);
		prog(2'h3, MODE_SINGLE, TYPE_READ, 1'b0, 1'b0, a, 16'h0000);
		begin_test;
		dreq <= 4'h8;
		repeat (2) @(posedge mclk);
		dreq <= 4'hA;
		wait_q(2);
		dreq <= 4'h0;
		idle;
		chk_bits(16'({q[0].ch, q[1].ch}), 16'h0007);
		rotate_priority <= 1'b1;
		grant_delay <= 3'h0;
		prog(2'h2, MODE_SINGLE, TYPE_READ, 1'b0, 1'b0, a, 16'h0000);
		prog(2'h0, MODE_SINGLE, TYPE_READ, 1'b0, 1'b0, a, 16'h0000);
		prog(2'h3, MODE_SINGLE, TYPE_READ, 1'b0, 1'b0, a, 16'h0000);
		begin_test;
		dreq <= 4'h4;
		wait_q(1);
		dreq <= 4'h9;
		wait_q(3);
		dreq <= 4'h0;
		idle;
		chk_bits(16'({q[0].ch, q[1].ch, q[2].ch}), 16'h002C);
		rotate_priority <= 1'b0;
		done("priority");

		prog(2'h2, MODE_CASCADE, TYPE_READ, 1'b0, 1'b0, a, 16'h0000);
		prog(2'h3, MODE_SINGLE, TYPE_READ, 1'b0, 1'b0, a, 16'h0000);
		begin_test;
		dreq <= 4'h4;
		repeat (10) @(posedge mclk);
		dreq <= 4'hC;
		repeat (10) @(posedge mclk);
		chk_bits(16'({dack_n, hlda}), 16'h0017);
		dreq <= 4'h0;
		idle;
		chk_bits(16'({seen, dack_n}), 16'h000F);
		chk_bits(16'(q.size()), 16'h0000);
		done("cascade");

		sd_in <= 8'($random(seed));
		m2m_enable <= 1'b1;
		ch0_addr_hold <= 1'b1;
		prog(2'h0, MODE_BLOCK, TYPE_READ, 1'b0, 1'b0, a, 16'h0002);
		prog(2'h1, MODE_BLOCK, TYPE_READ, 1'b0, 1'b0, ~a, 16'h0002);
		begin_test;
		sw_request <= 4'h1;
		for (k = 0; k < 2000 && tc_status[1] !== 1'b1; k++)
			@(posedge mclk);
		sw_request <= 4'h0;
		idle;
		m2m_enable <= 1'b0;
		ch0_addr_hold <= 1'b0;
		chk_bits(16'({tc_status[1], seen}), 16'h003C);
		expect_run(2'h1, 1'b0, ~a, 16'h0002);
		done("memory copy");
		tally_and_finish;
	end

	initial begin
		repeat (20000) @(posedge mclk);
		bad("watchdog expired");
		tally_and_finish;
	end
endmodule // dma_transfer_mode_sequencer_tb
